/* File: rtl/bbc_pkg.sv */
// Package for the branch and bit-clear execution slice: opcodes, flag positions, cycle counts, carriers.
package bbc_pkg;

  // ****************************************************************
  // Widths and cycle counts
  // ****************************************************************
  localparam int BBC_PC_W = 16;
  localparam logic [3:0] BBC_CLR_CYCLES = 4'h5;
  localparam logic [3:0] BBC_BR_CYCLES = 4'h3;
  localparam logic [15:0] BBC_BR_LEN = 16'h0002;
  localparam logic [7:0] BBC_DIR_HIGH = 8'h00;

  // ****************************************************************
  // Condition flag positions
  // ****************************************************************
  localparam int BBC_FLAG_H = 4;
  localparam int BBC_FLAG_I = 3;
  localparam int BBC_FLAG_N = 2;
  localparam int BBC_FLAG_Z = 1;
  localparam int BBC_FLAG_C = 0;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] BBC_OP_CLR_BASE = 8'h11;
  localparam logic [7:0] BBC_OP_CLR_LAST = 8'h1F;
  localparam logic [7:0] BBC_OP_BR_ALWAYS = 8'h20;
  localparam logic [7:0] BBC_OP_BR_NEVER = 8'h21;
  localparam logic [7:0] BBC_OP_BR_UGT = 8'h22;
  localparam logic [7:0] BBC_OP_BR_ULS = 8'h23;
  localparam logic [7:0] BBC_OP_BR_C0 = 8'h24;
  localparam logic [7:0] BBC_OP_BR_C1 = 8'h25;
  localparam logic [7:0] BBC_OP_BR_NE = 8'h26;
  localparam logic [7:0] BBC_OP_BR_EQ = 8'h27;
  localparam logic [7:0] BBC_OP_BR_H0 = 8'h28;
  localparam logic [7:0] BBC_OP_BR_H1 = 8'h29;
  localparam logic [7:0] BBC_OP_BR_POS = 8'h2A;
  localparam logic [7:0] BBC_OP_BR_NEG = 8'h2B;
  localparam logic [7:0] BBC_OP_BR_MC = 8'h2C;
  localparam logic [7:0] BBC_OP_BR_MS = 8'h2D;
  localparam logic [7:0] BBC_OP_BR_IRQ_LO = 8'h2E;
  localparam logic [7:0] BBC_OP_BR_IRQ_HI = 8'h2F;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [15:0] pc;
  } bbc_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
  } bbc_mem_t;

  typedef enum logic [2:0] {
    BBC_ST_IDLE = 3'h0,
    BBC_ST_RD = 3'h1,
    BBC_ST_WAIT = 3'h2,
    BBC_ST_WR = 3'h3,
    BBC_ST_BR = 3'h4,
    BBC_ST_DONE = 3'h5
  } bbc_state_t;

endpackage

/* File: rtl/bbc_cond.sv */
// Branch condition evaluator for the relative branch opcodes.
`timescale 1ns/1ps

module bbc_cond (
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] flags_in,
  input wire logic irq_pin_in,
  output logic is_branch_out,
  output logic take_out
);

  logic c;
  logic z;
  logic n;
  logic i;
  logic h;

  assign c = flags_in[bbc_pkg::BBC_FLAG_C];
  assign z = flags_in[bbc_pkg::BBC_FLAG_Z];
  assign n = flags_in[bbc_pkg::BBC_FLAG_N];
  assign i = flags_in[bbc_pkg::BBC_FLAG_I];
  assign h = flags_in[bbc_pkg::BBC_FLAG_H];

  always_comb begin
    is_branch_out = 1'b1;
    case (opcode_in)
      bbc_pkg::BBC_OP_BR_ALWAYS: take_out = 1'b1;
      bbc_pkg::BBC_OP_BR_NEVER: take_out = 1'b0;
      bbc_pkg::BBC_OP_BR_UGT: take_out = ~(c | z);
      bbc_pkg::BBC_OP_BR_ULS: take_out = c | z;
      bbc_pkg::BBC_OP_BR_C0: take_out = ~c;
      bbc_pkg::BBC_OP_BR_C1: take_out = c;
      bbc_pkg::BBC_OP_BR_NE: take_out = ~z;
      bbc_pkg::BBC_OP_BR_EQ: take_out = z;
      bbc_pkg::BBC_OP_BR_H0: take_out = ~h;
      bbc_pkg::BBC_OP_BR_H1: take_out = h;
      bbc_pkg::BBC_OP_BR_POS: take_out = ~n;
      bbc_pkg::BBC_OP_BR_NEG: take_out = n;
      bbc_pkg::BBC_OP_BR_MC: take_out = ~i;
      bbc_pkg::BBC_OP_BR_MS: take_out = i;
      bbc_pkg::BBC_OP_BR_IRQ_LO: take_out = ~irq_pin_in;
      bbc_pkg::BBC_OP_BR_IRQ_HI: take_out = irq_pin_in;
      default: begin
        is_branch_out = 1'b0;
        take_out = 1'b0;
      end
    endcase
  end

endmodule

/* File: rtl/bbc_exec.sv */
// Execution slice for memory bit clear and relative conditional branches.
`timescale 1ns/1ps

// Operation
// - Bit clear zeroes only bit n of the byte, other bits written back unchanged.
// - Bit clear operand is a direct address, high address byte zero.
// - Bit clear opcodes are 0x11 plus twice n; five cycles each.
// - Taken branch loads PC with instruction address plus 2 plus offset.
// - 0x25 branches on carry one, 0x24 on carry zero.
// - 0x27 branches on zero flag one, 0x26 on zero flag zero.
// - 0x28 branches when half carry is zero.
// - 0x29 branches when half carry is one.
// - 0x22 branches when carry and zero are both zero.
// - After compare, higher-or-same is taken when accumulator is unsigned greater or equal.
// - 0x2B/0x2A test negative one/zero; 0x2D/0x2C test mask one/zero.
// - 0x2F branches on interrupt pin high, 0x2E on pin low.
// - 0x20 always branches; 0x21 never branches but consumes its offset.
// - Branches are two bytes, three cycles, and change no flag.
// - The offset byte is sign-extended before it is added.
// - Flags come from the condition register: H4, I3, N2, Z1, C0.
module bbc_exec (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire bbc_pkg::bbc_instr_t instr_in,
  input wire logic [7:0] flags_in,
  input wire logic irq_pin_in,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output logic [15:0] pc_out,
  output logic taken_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output bbc_pkg::bbc_mem_t mem_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bbc_pkg::bbc_state_t state_q;
  bbc_pkg::bbc_state_t state_d;
  bbc_pkg::bbc_instr_t instr_q;
  logic [3:0] cyc_q;
  logic [2:0] bit_sel;
  logic is_clr;
  logic is_br;
  logic take;
  logic irq_s1_q;
  logic irq_s2_q;
  logic irq_s3_q;
  logic irq_level_q;
  logic [15:0] ofs_ext;
  logic [7:0] clr_mask;
  logic [16:0] next_pc_wide;
  logic [16:0] target_pc_wide;
  logic [15:0] next_pc;
  logic [15:0] target_pc;

  // ****************************************************************
  // Interrupt pin synchroniser
  // ****************************************************************
  // The pin is asynchronous; a change is accepted only once stages two and three agree.
  // Every stage resets high, the idle level of the pin, so reset alone never looks like a change.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      irq_s3_q <= 1'b1;
      irq_level_q <= 1'b1;
    end else begin
      irq_s1_q <= irq_pin_in;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (irq_s2_q == irq_s3_q) begin
        irq_level_q <= irq_s3_q;
      end
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Bit-clear opcodes are the odd values 0x11..0x1F; bits 3:1 carry n.
  assign is_clr = (instr_in.opcode >= bbc_pkg::BBC_OP_CLR_BASE) &&
                  (instr_in.opcode <= bbc_pkg::BBC_OP_CLR_LAST) && instr_in.opcode[0];

  bbc_cond u_cond (
    .opcode_in(instr_q.opcode),
    .flags_in(flags_in),
    .irq_pin_in(irq_level_q),
    .is_branch_out(is_br),
    .take_out(take)
  );

  // This second evaluator only classifies the incoming opcode. Its flag and pin inputs do not
  // matter, because the branch decision is made one cycle later from the captured instruction.
  logic start_br;
  bbc_cond u_cond_start (
    .opcode_in(instr_in.opcode),
    .flags_in(8'h00),
    .irq_pin_in(1'b0),
    .is_branch_out(start_br),
    .take_out()
  );

  assign bit_sel = instr_q.opcode[3:1];
  assign clr_mask = ~(8'h01 << bit_sel);
  // The offset is signed, so a byte with its top bit set branches backwards.
  assign ofs_ext = {{8{instr_q.operand[7]}}, instr_q.operand};

  // ****************************************************************
  // Branch target arithmetic
  // ****************************************************************
  // Both sums are formed one bit wider and cut on purpose, so a target past the top address wraps.
  assign next_pc_wide = {1'b0, instr_q.pc} + {1'b0, bbc_pkg::BBC_BR_LEN};
  assign next_pc = next_pc_wide[15:0];
  assign target_pc_wide = {1'b0, next_pc} + {1'b0, ofs_ext};
  assign target_pc = target_pc_wide[15:0];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      bbc_pkg::BBC_ST_IDLE: begin
        // A bit clear walks read, wait and write; a branch needs one evaluate cycle only.
        if (start_in && is_clr) begin
          state_d = bbc_pkg::BBC_ST_RD;
        end else if (start_in && start_br) begin
          state_d = bbc_pkg::BBC_ST_BR;
        end
      end
      bbc_pkg::BBC_ST_RD: state_d = bbc_pkg::BBC_ST_WAIT;
      bbc_pkg::BBC_ST_WAIT: state_d = bbc_pkg::BBC_ST_WR;
      bbc_pkg::BBC_ST_WR: state_d = bbc_pkg::BBC_ST_DONE;
      bbc_pkg::BBC_ST_BR: state_d = bbc_pkg::BBC_ST_DONE;
      bbc_pkg::BBC_ST_DONE: begin
        if (cyc_q == 4'h1) begin
          state_d = bbc_pkg::BBC_ST_IDLE;
        end
      end
      default: state_d = bbc_pkg::BBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= bbc_pkg::BBC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Cycle budget: the whole instruction occupies exactly its documented count, start cycle included.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc_q <= 4'h0;
      instr_q <= '0;
    end else if (state_q == bbc_pkg::BBC_ST_IDLE && start_in && (is_clr || start_br)) begin
      instr_q <= instr_in;
      cyc_q <= is_clr ? bbc_pkg::BBC_CLR_CYCLES - 4'h1 : bbc_pkg::BBC_BR_CYCLES - 4'h1;
    end else if (cyc_q != 4'h0) begin
      cyc_q <= cyc_q - 4'h1;
    end
  end

  // ****************************************************************
  // Memory access
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_out <= '0;
      mem_wr_out <= 1'b0;
    end else begin
      mem_wr_out <= 1'b0;
      // The memory answers one cycle after the read strobe, so its data is merged in the wait state.
      if (state_q == bbc_pkg::BBC_ST_WAIT) begin
        mem_out.wdata <= mem_rdata_in & clr_mask;
        mem_wr_out <= 1'b1;
      end
      if (state_d == bbc_pkg::BBC_ST_RD) begin
        mem_out.addr <= {bbc_pkg::BBC_DIR_HIGH, instr_in.operand};
      end
    end
  end

  assign mem_rd_out = (state_q == bbc_pkg::BBC_ST_RD);

  // ****************************************************************
  // Program counter result
  // ****************************************************************
  // Flags are only read here, never written, so branches leave the condition register alone.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_out <= 16'h0000;
      taken_out <= 1'b0;
    end else if (state_q == bbc_pkg::BBC_ST_BR) begin
      taken_out <= take & is_br;
      if (take) begin
        pc_out <= target_pc;
      end else begin
        pc_out <= next_pc;
      end
    end else if (state_q == bbc_pkg::BBC_ST_WAIT) begin
      // A bit clear is two bytes long as well, so it leaves the same next address.
      taken_out <= 1'b0;
      pc_out <= next_pc;
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  // These are decoded from state so the sequencer sees them at once. A start that meets a busy
  // slice is dropped without any flag; only an unknown opcode raises the illegal pulse.
  assign busy_out = (state_q != bbc_pkg::BBC_ST_IDLE);
  assign done_out = (state_q == bbc_pkg::BBC_ST_DONE) && (cyc_q == 4'h1);
  assign illegal_out = (state_q == bbc_pkg::BBC_ST_IDLE) && start_in && !is_clr && !start_br;

endmodule

/* File: verification/bbc_exec_props.sv */
// Concurrent checks on the ports of the execution slice.
`timescale 1ns/1ps
module bbc_exec_props (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire bbc_pkg::bbc_instr_t instr_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic illegal_out,
  input wire logic [15:0] pc_out,
  input wire logic taken_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire bbc_pkg::bbc_mem_t mem_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic go, clr, br, cy;
  logic [15:0] nxt, tgt;
  assign go = start_in && !busy_out;
  assign clr = go && instr_in.opcode[7:4] == 4'h1 && instr_in.opcode[0];
  assign br = go && instr_in.opcode[7:4] == 4'h2;
  assign nxt = instr_in.pc + 16'h0002;
  assign tgt = nxt + {{8{instr_in.operand[7]}}, instr_in.operand};
  assign cy = flags_in[0];
  logic [7:0] mask;
  logic op_always, op_never, op_carry, op_equal;
  assign mask = ~(8'h01 << instr_in.opcode[3:1]);
  assign op_always = br && instr_in.opcode == 8'h20;
  assign op_never = br && instr_in.opcode == 8'h21;
  assign op_carry = br && instr_in.opcode == 8'h25;
  assign op_equal = br && instr_in.opcode == 8'h27;
  sequence s_rmw;
    mem_rd_out ##2 mem_wr_out ##1 done_out;
  endsequence
  sequence s_br;
    busy_out && !done_out ##1 done_out ##1 !busy_out;
  endsequence
  chk_clr_steps: assert property (clr |=> s_rmw) else $error("bit clear steps wrong");
  chk_clr_addr: assert property (clr |=> mem_out.addr == {8'h00, $past(instr_in.operand)})
    else $error("direct address wrong");
  chk_clr_data: assert property (clr |-> ##3 mem_out.wdata == ($past(mem_rdata_in) & $past(mask, 3)))
    else $error("write back wrong");
  chk_clr_pc: assert property (clr |-> ##3 pc_out == $past(nxt, 3) && !taken_out)
    else $error("bit clear pc wrong");
  chk_br_steps: assert property (br |=> s_br) else $error("branch steps wrong");
  chk_br_always: assert property (op_always |-> ##2 pc_out == $past(tgt, 2) && taken_out)
    else $error("target wrong");
  chk_br_never: assert property (op_never |-> ##2 pc_out == $past(nxt, 2) && !taken_out)
    else $error("never wrong");
  chk_carry_test: assert property (op_carry ##1 1'b1 |=> taken_out == $past(cy))
    else $error("carry test wrong");
  chk_equal_pc: assert property (op_equal ##1 1'b1 |=>
    pc_out == ($past(flags_in[1]) ? $past(tgt, 2) : $past(nxt, 2))) else $error("equal branch pc wrong");
  chk_bad_skip: assert property (go && !clr && !br |-> illegal_out ##1 !busy_out)
    else $error("bad opcode run");
endmodule
bind bbc_exec bbc_exec_props i_props (.clock_in(clock_in), .rst_b_in(rst_b_in), .start_in(start_in),
  .instr_in(instr_in), .flags_in(flags_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out), .done_out(done_out),
  .illegal_out(illegal_out), .pc_out(pc_out), .taken_out(taken_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_out(mem_out));

/* File: verification/bbc_mem_model.sv */
// Page-zero data memory that answers the slice one cycle after a read.
`timescale 1ns/1ps
module bbc_mem_model (
  input wire logic clock_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire bbc_pkg::bbc_mem_t bus_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [256];
  initial rdata_out = 8'h3C;
  // Outside a read the data lines toggle, so stale data is never mistaken for an answer.
  always @(posedge clock_in) begin
    if (rd_in) begin
      rdata_out <= mem[bus_in.addr[7:0]];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (wr_in) begin
      mem[bus_in.addr[7:0]] <= bus_in.wdata;
    end
  end
endmodule

/* File: verification/bbc_exec_tb.sv */
// Self-checking bench for the bit clear and branch slice.
`timescale 1ns/1ps
module bbc_exec_tb;
  logic clock_in = 1'b0, rst_b_in = 1'b0, start_in = 1'b0, irq_pin_in = 1'b1;
  bbc_pkg::bbc_instr_t instr_in = '0;
  logic [7:0] flags_in = 8'h00, rdata;
  logic busy, done, illegal, taken, rd, wr;
  logic [15:0] pc;
  bbc_pkg::bbc_mem_t mem;
  int num_errors = 0, tests_run = 0;
  always #12.5 clock_in = ~clock_in;
  bbc_exec i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .start_in(start_in), .instr_in(instr_in),
    .flags_in(flags_in), .irq_pin_in(irq_pin_in), .mem_rdata_in(rdata), .busy_out(busy), .done_out(done),
    .illegal_out(illegal), .pc_out(pc), .taken_out(taken), .mem_rd_out(rd), .mem_wr_out(wr), .mem_out(mem));
  bbc_mem_model i_mem (.clock_in(clock_in), .rd_in(rd), .wr_in(wr), .bus_in(mem), .rdata_out(rdata));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] o, input logic [15:0] p, input logic [7:0] f);
    int k = 0;
    @(posedge clock_in);
    #1;
    instr_in = '{op, o, p};
    flags_in = f;
    start_in = 1'b1;
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    while (done !== 1'b1 && k < 8) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    chk(done === 1'b1, "no done");
  endtask
  function automatic logic take(input logic [7:0] op, input logic [7:0] f, input logic pin);
    logic b;
    case (op[3:1])
      3'h1: b = f[0] | f[1];
      3'h2: b = f[0];
      3'h3: b = f[1];
      3'h4: b = f[4];
      3'h5: b = f[2];
      3'h6: b = f[3];
      3'h7: b = pin;
      default: b = 1'b0;
    endcase
    return op[0] ? b : !b;
  endfunction
  task automatic t_clear;
    logic [7:0] a, v;
    for (int n = 0; n < 8; n++) begin
      a = n[0] ? 8'hFF : 8'h00;
      v = 8'hFF ^ (8'h80 >> n);
      i_mem.mem[a] = v;
      run(8'h11 + 8'(2 * n), a, 16'h0100, 8'h00);
      chk(i_mem.mem[a] === (v & ~(8'h01 << n)), "bit clear data");
      chk(pc === 16'h0102 && taken === 1'b0, "bit clear pc");
    end
    $display("bit clear test done");
  endtask
  task automatic t_branch;
    logic [7:0] f, o, op;
    logic [15:0] e;
    for (int p = 0; p < 2; p++) begin
      irq_pin_in = p[0];
      repeat (5) @(posedge clock_in);
      for (int k = 0; k < 16; k++) begin
        for (int j = 0; j < 7; j++) begin
          f = j == 5 ? 8'h00 : j == 6 ? 8'hFF : 8'h01 << j;
          o = j[0] ? 8'h80 : 8'h7F;
          op = 8'h20 + 8'(k);
          e = 16'h1002 + (take(op, f, p[0]) ? {{8{o[7]}}, o} : 16'h0000);
          run(op, o, 16'h1000, f);
          chk(taken === take(op, f, p[0]), "taken wrong");
          chk(pc === e, "branch pc wrong");
        end
      end
    end
    $display("branch test done");
  endtask
  task automatic t_compare;
    logic [7:0] av [3] = '{8'h10, 8'h0F, 8'hFF};
    logic [7:0] mv [3] = '{8'h10, 8'h10, 8'h00};
    foreach (av[i]) begin
      run(8'h24, 8'h04, 16'h2000, {6'h00, av[i] == mv[i], av[i] < mv[i]});
      chk(taken === (av[i] >= mv[i]), "compare branch wrong");
    end
    $display("compare test done");
  endtask
  task automatic t_illegal;
    logic [7:0] bad [3] = '{8'h10, 8'h12, 8'h30};
    foreach (bad[i]) begin
      @(posedge clock_in);
      #1;
      instr_in.opcode = bad[i];
      start_in = 1'b1;
      #1;
      chk(illegal === 1'b1, "no illegal flag");
      @(posedge clock_in);
      #1;
      start_in = 1'b0;
      chk(busy === 1'b0 && rd === 1'b0, "bad opcode started");
    end
    $display("illegal test done");
  endtask
  // A second start while busy, with another instruction on the inputs, must be ignored.
  task automatic t_refused;
    @(posedge clock_in);
    #1;
    instr_in = '{8'h20, 8'h10, 16'h3000};
    start_in = 1'b1;
    @(posedge clock_in);
    #1;
    instr_in = '{8'h11, 8'h00, 16'h4000};
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    chk(done === 1'b1 && rd === 1'b0, "start while busy taken");
    chk(pc === 16'h3012 && taken === 1'b1, "refused start changed pc");
    @(posedge clock_in);
    #1;
    chk(busy === 1'b0, "busy after branch");
    $display("refused start test done");
  endtask
  // Reset in the middle of a bit clear clears every output and leaves memory untouched.
  task automatic t_reset;
    i_mem.mem[8'h40] = 8'hFF;
    @(posedge clock_in);
    #1;
    instr_in = '{8'h1F, 8'h40, 16'h0500};
    start_in = 1'b1;
    @(posedge clock_in);
    #1;
    start_in = 1'b0;
    rst_b_in = 1'b0;
    #1;
    chk(busy === 1'b0 && rd === 1'b0 && pc === 16'h0000 && taken === 1'b0, "outputs not cleared");
    repeat (2) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    chk(wr === 1'b0 && done === 1'b0 && illegal === 1'b0, "strobes after reset");
    @(posedge clock_in);
    #1;
    chk(busy === 1'b0 && wr === 1'b0 && i_mem.mem[8'h40] === 8'hFF, "write after reset");
    $display("reset test done");
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    chk(busy === 1'b0 && done === 1'b0 && pc === 16'h0000 && taken === 1'b0, "reset state");
    chk(rd === 1'b0 && wr === 1'b0 && illegal === 1'b0, "reset strobes");
    t_clear;
    t_branch;
    t_compare;
    t_illegal;
    t_refused;
    t_reset;
    stop_test;
  end
  // About six times the expected run length, so a hang ends as a failure.
  initial begin
    #(25 * 5000);
    num_errors++;
    stop_test;
  end
endmodule
